// ==== rtl/pulse_fuse_regs.svh ====
// Constants of the pulse fuse programming logic: offsets, field layout, timing.
// Assumes a 25 MHz core clock and included by its bare name.
`ifndef PULSE_FUSE_REGS_SVH
`define PULSE_FUSE_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define PF_CLK_MHZ 25
`define PF_LOW_US 40
`define PF_ACTIVE_US 40
`define PF_BLOW_US 40
// Least times round up; whole microseconds at 25 MHz are exact.
`define PF_LOW_CYC (`PF_LOW_US * `PF_CLK_MHZ)
`define PF_ACTIVE_CYC (`PF_ACTIVE_US * `PF_CLK_MHZ)
`define PF_BLOW_CYC (`PF_BLOW_US * `PF_CLK_MHZ)
`define PF_CNT_W 11
`define PF_CNT_MAX 11'h7FF

// ****************************************
// Bit fields
// ****************************************
`define PF_GAIN_W 8
`define PF_FINEQ_W 8
`define PF_COARSE_W 2
`define PF_REG2_W 3
`define PF_LOCK_BIT 2
`define PF_KEY_W 2
`define PF_KEY_MAX 2'h3

// ****************************************
// Register map
// ****************************************
`define PF_ADDR_W 8
`define PF_CTRL_OFF 8'h00
`define PF_STATUS_OFF 8'h04
`define PF_TRIM_OFF 8'h08
`define PF_FUSE_OFF 8'h0C
`define PF_CTRL_EN_BIT 0
`define PF_CTRL_RST 1'h1
`define PF_RESP_OKAY 2'h0
`define PF_RESP_SLVERR 2'h2

`endif

// ==== rtl/pulse_fuse_pkg.sv ====
// Types shared by the pulse fuse programming logic.
// Assumes pulse_fuse_regs.svh for widths.
`include "pulse_fuse_regs.svh"

package pulse_fuse_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_INIT,
    ST_Z1_KEY,
    ST_Z1_CODE,
    ST_Z2_KEY,
    ST_Z2_CODE,
    ST_DONE
  } state_t;

  // Level qualifier state.
  typedef struct packed {
    logic [2:0] midSync;
    logic [2:0] highSync;
    logic midLvl;
    logic highLvl;
    logic [`PF_CNT_W-1:0] actCnt;
    logic [`PF_CNT_W-1:0] highCnt;
    logic [`PF_CNT_W-1:0] lowCnt;
    logic lowOk;
    logic midEvt;
    logic highEvt;
    logic blowEvt;
  } qual_t;

  // Sequencer and register slave state.
  typedef struct packed {
    state_t st;
    logic [`PF_KEY_W-1:0] z1Key;
    logic [`PF_KEY_W-1:0] z2Key;
    logic [`PF_GAIN_W-1:0] gainTry;
    logic [`PF_FINEQ_W-1:0] fineTry;
    logic [`PF_REG2_W-1:0] reg2Try;
    logic [`PF_GAIN_W-1:0] gainOut;
    logic [`PF_FINEQ_W-1:0] fineOut;
    logic [`PF_COARSE_W-1:0] coarseOut;
    logic blowStb;
    logic blowZ2;
    logic [`PF_KEY_W-1:0] blowRg;
    logic [7:0] blowBt;
    logic progEn;
    logic awHeld;
    logic [`PF_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } main_t;

endpackage : pulse_fuse_pkg

// ==== rtl/pulse_level_qualifier.sv ====
// Turns the two level comparators on the sensor output pin into pulse events.
// Assumes the comparators are asynchronous to ref_clk.
`timescale 1ns/1ns

module pulse_level_qualifier (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic midCmp,
  input wire logic highCmp,
  output logic midEvt,
  output logic highEvt,
  output logic blowEvt
);

  pulse_fuse_pkg::qual_t q, n; // Registered state and its next value.

  // ****************************************
  // Next state
  // ****************************************
  // Each comparator passes three flops; a level is accepted only once the
  // second and third agree, so metastable or glitchy edges are filtered.
  always_comb begin
    n = q;
    n.midEvt = 1'b0;
    n.highEvt = 1'b0;
    n.blowEvt = 1'b0;
    n.midSync = {q.midSync[1:0], midCmp};
    n.highSync = {q.highSync[1:0], highCmp};
    if (q.midSync[1] == q.midSync[2]) begin
      n.midLvl = q.midSync[2];
    end
    if (q.highSync[1] == q.highSync[2]) begin
      n.highLvl = q.highSync[2];
    end
    if (q.midLvl || q.highLvl) begin
      // Active level: time the pulse and its high part.
      n.lowCnt = '0;
      if (q.actCnt != `PF_CNT_MAX) begin
        n.actCnt = q.actCnt + `PF_CNT_W'(1);
      end
      if (q.highLvl && q.highCnt != `PF_CNT_MAX) begin
        n.highCnt = q.highCnt + `PF_CNT_W'(1);
      end
      // Blow strength reached once, while still high.
      if (q.highLvl && q.lowOk && q.highCnt == `PF_CNT_W'(`PF_BLOW_CYC - 1)) begin
        n.blowEvt = 1'b1;
      end
    end else begin
      // Falling edge: a pulse counts only if long enough and well separated.
      if (q.actCnt >= `PF_CNT_W'(`PF_ACTIVE_CYC) && q.lowOk) begin
        if (q.highCnt >= `PF_CNT_W'(`PF_ACTIVE_CYC)) begin
          n.highEvt = 1'b1;
        end else begin
          n.midEvt = 1'b1;
        end
      end
      if (q.actCnt != '0) begin
        n.lowOk = 1'b0;
      end else if (q.lowCnt >= `PF_CNT_W'(`PF_LOW_CYC)) begin
        n.lowOk = 1'b1;
      end
      n.actCnt = '0;
      n.highCnt = '0;
      if (q.lowCnt != `PF_CNT_MAX) begin
        n.lowCnt = q.lowCnt + `PF_CNT_W'(1);
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset clears everything; the clock enable freezes all state.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= n;
    end
  end

  assign midEvt = q.midEvt;
  assign highEvt = q.highEvt;
  assign blowEvt = q.blowEvt;

endmodule : pulse_level_qualifier

// ==== rtl/pulse_fuse_programming_logic.sv ====
// Programming sequencer of a trimmable sensor: pulse decoding, trial trim
// values, fuse blow strobes and an AXI4-Lite register slave.
// Assumes fuse sense inputs are stable from reset on and the comparators
// on the sensor output pin are asynchronous.
//
// Function
// - At most two key-code selections per power cycle.
// - First selection zone one, second zone two.
// - Zone two only after leaving zone one.
// - Blown fuse bits stay set forever.
// - Power cycle clears all unblown trial bits.
// - Pulses of 40 us are recognised.
// - Gain in Z1R1, fine/coarse quiescent in Z2.
// - Code pulses accepted after closing high pulse.
// - Third high enters zone two, then key.
// - Code pulse increments field, saturating at max.
// - Applied value is OR of trial and fuses.
// - Trim DAC updates right after each pulse.
// - Fine gain field is eight bits wide.
// - Result independent of fuse blowing order.
// - Key equals count of mid pulses.
// - Initial state ignores mid pulses until high.
// - Blown lock bit refuses all further programming.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns

module pulse_fuse_programming_logic (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Comparators on the sensor output pin, asynchronous.
  input wire logic midCmp,
  input wire logic highCmp,
  // Fuse sense lines, one per blown bit.
  input wire logic [`PF_GAIN_W-1:0] gainFuse,
  input wire logic [`PF_FINEQ_W-1:0] fineFuse,
  input wire logic [`PF_COARSE_W-1:0] coarseFuse,
  input wire logic lockFuse,
  // Trim DAC codes.
  output logic [`PF_GAIN_W-1:0] gainTrim,
  output logic [`PF_FINEQ_W-1:0] fineQuiescentTrim,
  output logic [`PF_COARSE_W-1:0] coarseQuiescentTrim,
  // Fuse blow request.
  output logic blowStrobe,
  output logic blowZone2,
  output logic [`PF_KEY_W-1:0] blowReg,
  output logic [7:0] blowBits,
  // AXI4-Lite slave.
  input wire logic [`PF_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`PF_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  pulse_fuse_pkg::main_t q, n; // Registered state and its next value.
  logic midEvt; // Qualified mid pulse, at its falling edge.
  logic highEvt; // Qualified high pulse, at its falling edge.
  logic blowEvt; // High level held long enough to blow.
  logic midOk; // Mid pulse allowed into the sequencer.
  logic highOk; // High pulse allowed into the sequencer.
  logic [`PF_REG2_W-1:0] reg2Fuse; // Zone two register 2 fuse image.

  // ****************************************
  // Pulse qualification
  // ****************************************
  pulse_level_qualifier qualifier (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .midCmp(midCmp),
    .highCmp(highCmp),
    .midEvt(midEvt),
    .highEvt(highEvt),
    .blowEvt(blowEvt)
  );

  // A blown lock, or software disabling, turns every pulse away.
  assign midOk = midEvt && q.progEn && !lockFuse;
  assign highOk = highEvt && q.progEn && !lockFuse;
  assign reg2Fuse = {lockFuse, coarseFuse};

  // ****************************************
  // Sequencer and register slave
  // ****************************************
  // One combinational block computes the whole next state. Pulse events
  // arrive at falling edges, so a code pulse can never be seen before the
  // high pulse that opens the bit field has ended.
  always_comb begin
    n = q;
    n.blowStb = 1'b0;
    unique case (q.st)
      pulse_fuse_pkg::ST_INIT: begin
        // Mid pulses are ignored here.
        if (highOk) begin
          n.st = pulse_fuse_pkg::ST_Z1_KEY;
        end
      end
      pulse_fuse_pkg::ST_Z1_KEY: begin
        if (midOk && q.z1Key != `PF_KEY_MAX) begin
          n.z1Key = q.z1Key + `PF_KEY_W'(1);
        end else if (highOk) begin
          n.st = pulse_fuse_pkg::ST_Z1_CODE;
        end
      end
      pulse_fuse_pkg::ST_Z1_CODE: begin
        // Only register 1 exists in zone one: the fine gain field.
        if (midOk && q.z1Key == `PF_KEY_W'(1)) begin
          if (q.gainTry != {`PF_GAIN_W{1'b1}}) begin
            n.gainTry = q.gainTry + `PF_GAIN_W'(1);
          end
        end else if (highOk) begin
          n.st = pulse_fuse_pkg::ST_Z2_KEY;
        end
      end
      pulse_fuse_pkg::ST_Z2_KEY: begin
        // A high pulse with no key blows the zone one field.
        if (blowEvt && q.progEn && !lockFuse && q.z2Key == '0) begin
          if (q.z1Key == `PF_KEY_W'(1) && q.gainTry != '0) begin
            n.blowStb = 1'b1;
            n.blowZ2 = 1'b0;
            n.blowRg = q.z1Key;
            n.blowBt = q.gainTry;
            n.st = pulse_fuse_pkg::ST_DONE;
          end
        end else if (midOk && q.z2Key != `PF_KEY_MAX) begin
          n.z2Key = q.z2Key + `PF_KEY_W'(1);
        end else if (highOk && q.z2Key != '0) begin
          n.st = pulse_fuse_pkg::ST_Z2_CODE;
        end
      end
      pulse_fuse_pkg::ST_Z2_CODE: begin
        if (blowEvt && q.progEn && !lockFuse) begin
          // The next high pulse after the code is the blow pulse.
          if (q.z2Key == `PF_KEY_W'(1) && q.fineTry != '0) begin
            n.blowStb = 1'b1;
            n.blowBt = q.fineTry;
          end else if (q.z2Key == `PF_KEY_W'(2) && q.reg2Try != '0) begin
            n.blowStb = 1'b1;
            n.blowBt = {5'h0, q.reg2Try};
          end
          n.blowZ2 = 1'b1;
          n.blowRg = q.z2Key;
          n.st = pulse_fuse_pkg::ST_DONE;
        end else if (midOk && q.z2Key == `PF_KEY_W'(1)) begin
          if (q.fineTry != {`PF_FINEQ_W{1'b1}}) begin
            n.fineTry = q.fineTry + `PF_FINEQ_W'(1);
          end
        end else if (midOk && q.z2Key == `PF_KEY_W'(2)) begin
          if (q.reg2Try != {`PF_REG2_W{1'b1}}) begin
            n.reg2Try = q.reg2Try + `PF_REG2_W'(1);
          end
        end
      end
      pulse_fuse_pkg::ST_DONE: begin
        // No third selection is taken before the next power cycle.
        n.st = pulse_fuse_pkg::ST_DONE;
      end
    endcase
    // Trial bits OR blown bits: blowing order cannot matter, and a
    // blown bit is always on whatever the trial holds.
    n.gainOut = q.gainTry | gainFuse;
    n.fineOut = q.fineTry | fineFuse;
    n.coarseOut = q.reg2Try[`PF_COARSE_W-1:0] | coarseFuse;

    // Write channel: address and data are latched independently.
    if (awvalid && !q.awHeld && !q.bValid) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && !q.wHeld && !q.bValid) begin
      n.wHeld = 1'b1;
      n.wData = wdata;
      n.wLane0 = wstrb[0];
    end
    if (q.awHeld && q.wHeld && !q.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = `PF_RESP_OKAY;
      if (q.awAddr == `PF_CTRL_OFF) begin
        if (q.wLane0) begin
          n.progEn = q.wData[`PF_CTRL_EN_BIT];
        end
      end else if (q.awAddr != `PF_STATUS_OFF && q.awAddr != `PF_TRIM_OFF &&
                   q.awAddr != `PF_FUSE_OFF) begin
        n.bResp = `PF_RESP_SLVERR;
      end
    end else if (q.bValid && bready) begin
      n.bValid = 1'b0;
    end

    // Read channel: one read at a time, answered the cycle after arvalid.
    if (arvalid && !q.rValid) begin
      n.rValid = 1'b1;
      n.rResp = `PF_RESP_OKAY;
      n.rData = '0;
      case (araddr)
        `PF_CTRL_OFF: n.rData = {31'h0, q.progEn};
        `PF_STATUS_OFF: n.rData = {23'h0, lockFuse, 1'b0, q.z2Key, q.z1Key, q.st};
        `PF_TRIM_OFF: n.rData = {13'h0, q.reg2Try, q.fineOut, q.gainOut};
        `PF_FUSE_OFF: n.rData = {13'h0, reg2Fuse, fineFuse, gainFuse};
        default: n.rResp = `PF_RESP_SLVERR;
      endcase
    end else if (q.rValid && rready) begin
      n.rValid = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // The synchronous reset is the power-on reset: it alone clears the
  // selection state and every trial bit. Fuses live outside and survive.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= pulse_fuse_pkg::ST_INIT;
      q.progEn <= `PF_CTRL_RST;
    end else if (clkEn) begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign gainTrim = q.gainOut;
  assign fineQuiescentTrim = q.fineOut;
  assign coarseQuiescentTrim = q.coarseOut;
  assign blowStrobe = q.blowStb;
  assign blowZone2 = q.blowZ2;
  assign blowReg = q.blowRg;
  assign blowBits = q.blowBt;
  // Handshake readies are combinational on held state.
  assign awready = !q.awHeld && !q.bValid;
  assign wready = !q.wHeld && !q.bValid;
  assign bvalid = q.bValid;
  assign bresp = q.bResp;
  assign arready = !q.rValid;
  assign rvalid = q.rValid;
  assign rdata = q.rData;
  assign rresp = q.rResp;

endmodule : pulse_fuse_programming_logic

// ==== dv/pulse_fuse_assertions.sv ====
// Concurrent checks on the ports of the pulse fuse programming logic.
// Assumes one clock, ref_clk, and the synchronous active-high sys_rst.
`timescale 1ns/1ns
`include "pulse_fuse_regs.svh"

module pulse_fuse_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic highCmp,
  input wire logic [`PF_GAIN_W-1:0] gainFuse,
  input wire logic [`PF_FINEQ_W-1:0] fineFuse,
  input wire logic lockFuse,
  input wire logic [`PF_GAIN_W-1:0] gainTrim,
  input wire logic [`PF_FINEQ_W-1:0] fineQuiescentTrim,
  input wire logic blowStrobe,
  input wire logic blowZone2,
  input wire logic [`PF_KEY_W-1:0] blowReg,
  input wire logic [7:0] blowBits,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  // ****************************************
  // Checks
  // ****************************************
  // Everything runs on ref_clk and is muted while reset is applied.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // A write completes only once both address and data have been taken.
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdTaken;
    arvalid && arready;
  endsequence

  strobe_one_cycle_a: assert property (blowStrobe |=> !blowStrobe)
    else $error("blow strobe longer than one cycle");
  strobe_in_blow_a: assert property (blowStrobe |-> highCmp && blowBits != 8'h00)
    else $error("blow strobe outside a blow pulse");
  lock_blocks_blow_a: assert property (lockFuse |-> !blowStrobe)
    else $error("blow strobe on a locked part");
  fuse_kept_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    (gainTrim & gainFuse) == gainFuse && (fineQuiescentTrim & fineFuse) == fineFuse)
    else $error("blown fuse bit lost from trim");
  reset_trims_a: assert property ($fell(sys_rst) |-> ##2
    gainTrim == gainFuse && fineQuiescentTrim == fineFuse)
    else $error("trial bits survived power cycle");
  gain_step_a: assert property (!$past(sys_rst) && gainFuse == 8'h00 &&
    $changed(gainTrim) |-> gainTrim == $past(gainTrim) + 8'h01)
    else $error("gain trim did not step by one");
  zone1_blow_a: assert property (blowStrobe && !blowZone2 && gainFuse == 8'h00 |->
    blowReg == 2'h1 && blowBits == gainTrim)
    else $error("zone one blow targets wrong bits");
  write_answer_a: assert property (wrTaken |-> ##2 bvalid)
    else $error("write response late");
  read_answer_a: assert property (rdTaken |=> rvalid)
    else $error("read response late");
  bus_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken before response");
endmodule : pulse_fuse_assertions

// ==== dv/pulse_programmer_model.sv ====
// Behavioural external programmer that shapes three-level pulses on the pin.
// Assumes the pin level reaches the device as two comparator outputs.
`timescale 1ns/1ns
`include "pulse_fuse_regs.svh"

module pulse_programmer_model (
  input wire logic ref_clk,
  output logic midCmp,
  output logic highCmp
);
  // Margins cover the synchroniser delay inside the qualifier.
  localparam int LowCyc = `PF_LOW_CYC + 10;
  localparam int ActCyc = `PF_ACTIVE_CYC + 20;

  // The pin idles at the low level.
  initial begin
    midCmp = 1'b0;
    highCmp = 1'b0;
  end

  // ****************************************
  // Pulse tasks
  // ****************************************
  // One pulse: low separation, active level, then a short settle.
  task automatic pulse(input logic high);
    repeat (LowCyc) @(posedge ref_clk);
    midCmp <= 1'b1;
    highCmp <= high;
    repeat (ActCyc) @(posedge ref_clk);
    midCmp <= 1'b0;
    highCmp <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask : pulse

  // A train of mid pulses forms a key or a code.
  task automatic mids(input int n);
    repeat (n) pulse(1'b0);
  endtask : mids

  // Register selection is a high pulse, the key, and a closing high pulse.
  task automatic select(input int key);
    pulse(1'b1);
    mids(key);
    pulse(1'b1);
  endtask : select
endmodule : pulse_programmer_model

// ==== dv/pulse_fuse_programming_logic_tb.sv ====
// Self-checking bench of the pulse fuse programming logic.
// Assumes the programmer model drives the pin comparators.
`timescale 1ns/1ns
`include "pulse_fuse_regs.svh"

module pulse_fuse_programming_logic_tb;
  logic ref_clk = 1'b0;
  logic sys_rst, clkEn, lockFuse;
  logic midCmp, highCmp, blowStrobe, blowZone2, awready, wready, bvalid, arready, rvalid;
  logic [`PF_GAIN_W-1:0] gainFuse, gainTrim;
  logic [`PF_FINEQ_W-1:0] fineFuse, fineQuiescentTrim;
  logic [`PF_COARSE_W-1:0] coarseFuse, coarseQuiescentTrim;
  logic [`PF_KEY_W-1:0] blowReg;
  logic [7:0] blowBits, awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [1:0] bresp, rresp;
  logic [10:0] lastBlow = 11'h0;
  int strobeCnt = 0;
  int errCount = 0;
  int checkCount = 0;

  pulse_fuse_programming_logic DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .midCmp(midCmp), .highCmp(highCmp), .gainFuse(gainFuse), .fineFuse(fineFuse),
    .coarseFuse(coarseFuse), .lockFuse(lockFuse), .gainTrim(gainTrim),
    .fineQuiescentTrim(fineQuiescentTrim), .coarseQuiescentTrim(coarseQuiescentTrim),
    .blowStrobe(blowStrobe), .blowZone2(blowZone2), .blowReg(blowReg), .blowBits(blowBits),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  pulse_programmer_model prog (.ref_clk(ref_clk), .midCmp(midCmp), .highCmp(highCmp));

  // A 40 ns clock.
  always #20 ref_clk = ~ref_clk;

  // Record every blow request, since the strobe lasts a single cycle.
  always @(posedge ref_clk) begin
    if (blowStrobe === 1'b1) begin
      strobeCnt <= strobeCnt + 1;
      lastBlow <= {blowZone2, blowReg, blowBits};
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Write with address and data offered together; bready stays up until bvalid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  // Read and compare the masked word and the response code.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // A power cycle; fuse sense lines only change while the part is unpowered.
  task automatic doReset(input logic [7:0] g, input logic [7:0] f, input logic [1:0] c,
                         input logic l);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    gainFuse <= g;
    fineFuse <= f;
    coarseFuse <= c;
    lockFuse <= l;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : doReset

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testBus;
    rd(`PF_CTRL_OFF, 32'h1, {31'h0, `PF_CTRL_RST}, `PF_RESP_OKAY);
    rd(`PF_STATUS_OFF, 32'h1FF, 32'h0, `PF_RESP_OKAY);
    wr(`PF_STATUS_OFF, 32'hFFFFFFFF, `PF_RESP_OKAY);
    rd(`PF_STATUS_OFF, 32'h1FF, 32'h0, `PF_RESP_OKAY);
    wr(8'h10, 32'h0, `PF_RESP_SLVERR);
    rd(8'h10, 32'h0, 32'h0, `PF_RESP_SLVERR);
    rd(`PF_FUSE_OFF, 32'h7FFFF, 32'h0, `PF_RESP_OKAY);
    $display("test bus done");
  endtask : testBus

  // Hold both zones in trial, then blow the fine quiescent code.
  task automatic testTry;
    int n;
    prog.pulse(1'b0);
    rd(`PF_STATUS_OFF, 32'h7, 32'h0, `PF_RESP_OKAY);
    prog.select(1);
    rd(`PF_STATUS_OFF, 32'h1F, 32'h0A, `PF_RESP_OKAY);
    for (int i = 1; i <= 3; i++) begin
      prog.pulse(1'b0);
      chk({24'h0, gainTrim}, 32'(i));
    end
    prog.select(1);
    rd(`PF_STATUS_OFF, 32'h7F, 32'h2C, `PF_RESP_OKAY);
    prog.mids(2);
    chk({24'h0, fineQuiescentTrim}, 32'h2);
    chk({24'h0, gainTrim}, 32'h3);
    n = strobeCnt;
    prog.pulse(1'b1);
    chk(32'(strobeCnt - n), 32'h1);
    chk({21'h0, lastBlow}, 32'h502);
    prog.pulse(1'b1);
    prog.mids(1);
    rd(`PF_STATUS_OFF, 32'h7, 32'h5, `PF_RESP_OKAY);
    $display("test try done");
  endtask : testTry

  task automatic testBlowOne;
    int n;
    doReset(8'h00, 8'h00, 2'h0, 1'b0);
    prog.select(1);
    prog.mids(1);
    n = strobeCnt;
    prog.pulse(1'b1);
    prog.pulse(1'b1);
    chk(32'(strobeCnt - n), 32'h1);
    chk({21'h0, lastBlow}, 32'h101);
    $display("test blow done");
  endtask : testBlowOne

  // Blown bits survive the power cycle and combine with trial codes.
  task automatic testPowerCycle;
    doReset(8'h01, 8'h40, 2'h2, 1'b0);
    chk({24'h0, gainTrim}, 32'h01);
    chk({24'h0, fineQuiescentTrim}, 32'h40);
    chk({30'h0, coarseQuiescentTrim}, 32'h2);
    rd(`PF_STATUS_OFF, 32'h7F, 32'h0, `PF_RESP_OKAY);
    rd(`PF_FUSE_OFF, 32'h7FFFF, 32'h24001, `PF_RESP_OKAY);
    prog.select(1);
    prog.mids(2);
    chk({24'h0, gainTrim}, 32'h03);
    // A high pulse sent while the clock enable is low must not leave zone one.
    @(posedge ref_clk);
    clkEn <= 1'b0;
    prog.pulse(1'b1);
    clkEn <= 1'b1;
    rd(`PF_STATUS_OFF, 32'h7, 32'h2, `PF_RESP_OKAY);
    $display("test power cycle done");
  endtask : testPowerCycle

  // Pass zone one untouched, then overrun the three-bit register two code.
  task automatic testZoneTwoSat;
    doReset(8'h00, 8'h00, 2'h0, 1'b0);
    prog.pulse(1'b1);
    prog.pulse(1'b1);
    prog.select(2);
    prog.mids(8);
    rd(`PF_TRIM_OFF, 32'h70000, 32'h70000, `PF_RESP_OKAY);
    chk({30'h0, coarseQuiescentTrim}, 32'h3);
    $display("test zone two done");
  endtask : testZoneTwoSat

  task automatic testLocked;
    doReset(8'h00, 8'h00, 2'h0, 1'b1);
    prog.select(1);
    prog.mids(1);
    chk({24'h0, gainTrim}, 32'h0);
    rd(`PF_STATUS_OFF, 32'h1FF, 32'h100, `PF_RESP_OKAY);
    doReset(8'h00, 8'h00, 2'h0, 1'b0);
    wr(`PF_CTRL_OFF, 32'h0, `PF_RESP_OKAY);
    rd(`PF_CTRL_OFF, 32'h1, 32'h0, `PF_RESP_OKAY);
    prog.pulse(1'b1);
    rd(`PF_STATUS_OFF, 32'h7, 32'h0, `PF_RESP_OKAY);
    $display("test locked done");
  endtask : testLocked

  // ****************************************
  // Run control
  // ****************************************
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : endOfTest

  // Reset is held for five cycles, then every scenario runs in turn.
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    lockFuse = 1'b0;
    gainFuse = 8'h00;
    fineFuse = 8'h00;
    coarseFuse = 2'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    testBus();
    testTry();
    testBlowOne();
    testPowerCycle();
    testZoneTwoSat();
    testLocked();
    endOfTest();
  end

  // The scenarios need about 94400 cycles; a hang is cut off a little past that.
  initial begin
    repeat (105000) @(posedge ref_clk);
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    endOfTest();
  end
endmodule : pulse_fuse_programming_logic_tb

bind pulse_fuse_programming_logic pulse_fuse_assertions portChecks (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .highCmp(highCmp), .gainFuse(gainFuse), .fineFuse(fineFuse),
  .lockFuse(lockFuse), .gainTrim(gainTrim), .fineQuiescentTrim(fineQuiescentTrim),
  .blowStrobe(blowStrobe), .blowZone2(blowZone2), .blowReg(blowReg), .blowBits(blowBits),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid));
